// [rtl/channel_transport_cfg.svh]
// Constants of the channel transport command handler
// Summary of operation
// - Reject unsupported or malformed revision requests
// - Without legacy support, reject revision zero
// - Reject commands outside the selected revision
// - Reject selecting a different revision later
// - Revision unset while subchannel is disabled
// - Early commands: reject, or adopt revision zero
// - Queue config read returns maximum queue size from QMAX
// - Modern set-queue layout; reserved word ignored
// - Revision zero uses legacy set-queue layout
// - Refused status write keeps status, rejects
// - Status read returns status from revision two
// - Feature block: little-endian word plus index
// - Config commands move whole configuration space
// - Classic setup rejected after adapter setup
// - Classic indicator address is 64 bits
// - Config-change indicator has its own address
// - Adapter block: summary, area, bit, subclass
// - One indicator bit per queue, MSB first
// - Multi-byte fields big-endian except features
`ifndef CHANNEL_TRANSPORT_CFG_SVH
`define CHANNEL_TRANSPORT_CFG_SVH
// Channel command codes
`define CMD_SET_QUEUE 8'h13
`define CMD_DEV_RESET 8'h33
`define CMD_CLASSIC_IND 8'h43
`define CMD_CFG_IND 8'h53
`define CMD_ADAPTER_IND 8'h73
`define CMD_RD_FEAT 8'h12
`define CMD_WR_FEAT 8'h11
`define CMD_RD_CFG 8'h22
`define CMD_WR_CFG 8'h21
`define CMD_WR_STATUS 8'h31
`define CMD_RD_QCFG 8'h32
`define CMD_SET_REV 8'h83
`define CMD_RD_STATUS 8'h72
// Revisions
`define REV_MAX 2'h2
`define REV_STATUS 2'h2
// Block lengths in bytes
`define LEN_REV 6'h04
`define LEN_VQ 6'h20
`define LEN_VQ_OLD 6'h10
`define LEN_QCFG_IN 6'h02
`define LEN_QCFG_OUT 6'h02
`define LEN_STATUS 6'h01
`define LEN_FEAT 6'h05
`define LEN_FEAT_OUT 6'h04
`define LEN_CFG 6'h04
`define LEN_IND 6'h08
`define LEN_ADAPTER 6'h19
// Field positions in the receive shift register
`define REV_ID_LSB 16
`define VQ_DESC_LSB 192
`define VQ_INDEX_LSB 144
`define VQ_NUM_LSB 128
`define VQ_AVAIL_LSB 64
`define OLD_ADDR_LSB 64
`define OLD_ALIGN_LSB 32
`define OLD_INDEX_LSB 16
`define AD_SUMMARY_LSB 136
`define AD_AREA_LSB 72
`define AD_BIT_LSB 8
// Register offsets
`define REG_CTRL 8'h00
`define REG_DEV_FEAT0 8'h04
`define REG_DEV_FEAT1 8'h08
`define REG_QMAX 8'h0C
`define REG_CFG 8'h10
`define REG_STATUS_MASK 8'h14
`define REG_STATE 8'h18
`define REG_DRV_FEAT0 8'h1C
`define REG_DRV_FEAT1 8'h20
// Reset values
`define CTRL_RST 1'h0
`define QMAX_RST 16'h0100
`define STATUS_MASK_RST 8'hFF
`endif

// [rtl/channel_transport_pkg.sv]
// Types of the channel transport command handler
package channel_transport_pkg;
	// Command sequencer, Gray along idle-receive-execute-transmit
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RX = 2'h1,
		ST_EXEC = 2'h3,
		ST_TX = 2'h2
	} state_type;
	// Queue indicator mode
	typedef enum logic [1:0] {
		IND_NONE = 2'h0,
		IND_CLASSIC = 2'h1,
		IND_ADAPTER = 2'h2
	} ind_mode_type;
endpackage

// [rtl/channel_transport_command_handler.sv]
// Device-side interpreter of transport-specific channel commands
`timescale 1ns/10ps
`include "channel_transport_cfg.svh"
module channel_transport_command_handler (
	input wire logic clk_sys_i, // 40 MHz clock
	input wire logic rst_n_i, // Synchronous reset
	input wire logic subch_enable_i, // Subchannel enabled
	input wire logic cmd_valid_i, // Command start pulse
	input wire logic [7:0] cmd_code_i, // Command code
	input wire logic [15:0] cmd_len_i, // Data count of command
	input wire logic din_valid_i, // Guest data byte valid
	input wire logic [7:0] din_i, // Guest data byte
	output logic din_ready_o, // Ready for guest bytes
	output logic dout_valid_o, // Device data byte valid
	output logic [7:0] dout_o, // Device data byte
	output logic done_o, // Command ended pulse
	output logic reject_o, // Unit check, command reject
	input wire logic [7:0] reg_addr_i, // Register address
	input wire logic [31:0] reg_wdata_i, // Register write data
	input wire logic reg_wr_i, // Register write strobe
	input wire logic reg_rd_i, // Register read strobe
	output logic [31:0] reg_rdata_o, // Register read data
	output logic q_wr_o, // Queue programmed pulse
	output logic [15:0] q_index_o, // Queue index
	output logic [15:0] q_num_o, // Queue size
	output logic [63:0] q_desc_o, // Descriptor or legacy queue address
	output logic [31:0] q_align_o, // Legacy alignment
	output logic [63:0] q_avail_o, // Available area address
	output logic [63:0] q_used_o, // Used area address
	output logic [63:0] classic_ind_addr_o, // Classic indicators
	output logic [63:0] cfg_ind_addr_o, // Config-change indicators
	output logic [63:0] summary_addr_o, // Summary byte address
	output logic [63:0] ind_area_addr_o, // Indicator area address
	output logic [63:0] start_bit_o, // First queue bit
	output logic [7:0] irq_subclass_o, // Adapter subclass
	output logic [1:0] ind_mode_o, // Indicator mode
	output logic [7:0] status_o, // Device status
	input wire logic notify_i, // Queue notify request
	input wire logic [15:0] notify_q_i, // Queue to notify
	output logic notify_o, // Indicator bit to set
	output logic [63:0] notify_addr_o, // Byte holding the bit
	output logic [7:0] notify_mask_o // Bit within the byte
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	channel_transport_pkg::state_type state_q;
	channel_transport_pkg::ind_mode_type mode_q;
	logic [7:0] code_q;
	logic [5:0] cnt_q;
	logic [5:0] out_len_q;
	logic [31:0] out_q;
	logic [255:0] rx_q;
	logic rev_set_q;
	logic implied_q;
	logic [1:0] rev_q;
	logic legacy_ok_q;
	logic [15:0] qmax_q;
	logic [31:0] cfg_q;
	logic [7:0] status_mask_q;
	logic [31:0] dev_feat_q [0:1];
	logic [31:0] drv_feat_q [0:1];
	logic [1:0] eff_rev;
	logic known;
	logic [5:0] need_in;
	logic [5:0] need_out;
	logic [5:0] need;
	logic dec_rej;
	logic exec_rej;
	logic [31:0] feat_word;
	logic [15:0] new_rev;
	logic [63:0] bit_pos;
	logic exec;
	logic [7:0] status_q;

	assign status_o = status_q;
	assign ind_mode_o = mode_q;

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Revision in force: an unset revision decodes as zero
	assign eff_rev = rev_set_q ? rev_q : 2'h0;
	assign exec = (state_q == channel_transport_pkg::ST_EXEC);
	assign new_rev = rx_q[`REV_ID_LSB +: 16];

	// Byte counts each command moves
	always_comb begin
		known = 1'b1;
		need_in = 6'h00;
		need_out = 6'h00;
		case (cmd_code_i)
			`CMD_SET_REV: need_in = `LEN_REV;
			`CMD_SET_QUEUE: need_in = (eff_rev == 2'h0) ? `LEN_VQ_OLD : `LEN_VQ;
			`CMD_RD_QCFG: begin
				need_in = `LEN_QCFG_IN;
				need_out = `LEN_QCFG_OUT;
			end
			`CMD_WR_STATUS: need_in = `LEN_STATUS;
			`CMD_RD_STATUS: need_out = `LEN_STATUS;
			`CMD_WR_FEAT: need_in = `LEN_FEAT;
			`CMD_RD_FEAT: begin
				need_in = `LEN_FEAT;
				need_out = `LEN_FEAT_OUT;
			end
			`CMD_RD_CFG: need_out = `LEN_CFG;
			`CMD_WR_CFG: need_in = `LEN_CFG;
			`CMD_CLASSIC_IND: need_in = `LEN_IND;
			`CMD_CFG_IND: need_in = `LEN_IND;
			`CMD_ADAPTER_IND: need_in = `LEN_ADAPTER;
			`CMD_DEV_RESET: need_in = 6'h00;
			default: known = 1'b0;
		endcase
		need = (need_in > need_out) ? need_in : need_out;
	end

	// Refusal before any data moves; a short buffer cannot be processed
	assign dec_rej = !known
		|| (!rev_set_q && cmd_code_i != `CMD_SET_REV && !legacy_ok_q)
		|| (cmd_code_i == `CMD_RD_STATUS && eff_rev < `REV_STATUS)
		|| (cmd_code_i == `CMD_SET_REV && implied_q)
		|| (cmd_len_i < {10'h000, need});

	// Refusal once the block is in
	always_comb begin
		exec_rej = 1'b0;
		case (code_q)
			`CMD_SET_REV: exec_rej = new_rev > {14'h0000, `REV_MAX}
				|| rx_q[15:0] != 16'h0000
				|| (new_rev == 16'h0000 && !legacy_ok_q)
				|| (rev_set_q && new_rev[1:0] != rev_q);
			`CMD_WR_STATUS: exec_rej = |(rx_q[7:0] & ~status_mask_q);
			`CMD_CLASSIC_IND: exec_rej = (mode_q == channel_transport_pkg::IND_ADAPTER);
			`CMD_ADAPTER_IND: exec_rej = (mode_q == channel_transport_pkg::IND_CLASSIC);
			default: exec_rej = 1'b0;
		endcase
	end

	// Feature word selected by the block's index byte
	assign feat_word = (rx_q[7:1] == 7'h00) ? dev_feat_q[rx_q[0]] : 32'h0000_0000;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Commands arriving while busy are ignored; the channel waits for done
	always_ff @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		dout_valid_o <= 1'b0;
		if (!rst_n_i) begin
			state_q <= channel_transport_pkg::ST_IDLE;
			code_q <= 8'h00;
			cnt_q <= 6'h00;
			out_len_q <= 6'h00;
			out_q <= 32'h0000_0000;
			rx_q <= '0;
			din_ready_o <= 1'b0;
			dout_o <= 8'h00;
			reject_o <= 1'b0;
		end else begin
			case (state_q)
				channel_transport_pkg::ST_IDLE: begin
					if (cmd_valid_i) begin
						code_q <= cmd_code_i;
						out_len_q <= need_out;
						cnt_q <= need_in;
						reject_o <= dec_rej;
						if (dec_rej) begin
							done_o <= 1'b1;
						end else if (need_in != 6'h00) begin
							din_ready_o <= 1'b1;
							state_q <= channel_transport_pkg::ST_RX;
						end else begin
							state_q <= channel_transport_pkg::ST_EXEC;
						end
					end
				end
				channel_transport_pkg::ST_RX: begin
					if (din_valid_i) begin
						rx_q <= {rx_q[247:0], din_i}; // first byte most significant
						cnt_q <= cnt_q - 6'h01;
						if (cnt_q == 6'h01) begin
							din_ready_o <= 1'b0;
							state_q <= channel_transport_pkg::ST_EXEC;
						end
					end
				end
				channel_transport_pkg::ST_EXEC: begin
					reject_o <= exec_rej;
					cnt_q <= out_len_q;
					case (code_q)
						`CMD_RD_QCFG: out_q <= {qmax_q, 16'h0000};
						`CMD_RD_STATUS: out_q <= {status_q, 24'h000000};
						`CMD_RD_FEAT: out_q <= {feat_word[7:0], feat_word[15:8],
							feat_word[23:16], feat_word[31:24]};
						`CMD_RD_CFG: out_q <= cfg_q;
						default: out_q <= 32'h0000_0000;
					endcase
					if (exec_rej || out_len_q == 6'h00) begin
						done_o <= 1'b1;
						state_q <= channel_transport_pkg::ST_IDLE;
					end else begin
						state_q <= channel_transport_pkg::ST_TX;
					end
				end
				channel_transport_pkg::ST_TX: begin
					dout_valid_o <= 1'b1;
					dout_o <= out_q[31:24];
					out_q <= {out_q[23:0], 8'h00};
					cnt_q <= cnt_q - 6'h01;
					if (cnt_q == 6'h01) begin
						done_o <= 1'b1;
						state_q <= channel_transport_pkg::ST_IDLE;
					end
				end
				default: state_q <= channel_transport_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Revision
	// ****************************************************************
	// Forgotten whenever the subchannel is off, so enabling starts unset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !subch_enable_i) begin
			rev_set_q <= 1'b0;
			implied_q <= 1'b0;
			rev_q <= 2'h0;
		end else if (state_q == channel_transport_pkg::ST_IDLE && cmd_valid_i && !dec_rej
			&& !rev_set_q && cmd_code_i != `CMD_SET_REV) begin
			rev_set_q <= 1'b1; // legacy driver assumed
			implied_q <= 1'b1;
			rev_q <= 2'h0;
		end else if (exec && code_q == `CMD_SET_REV && !exec_rej) begin
			rev_set_q <= 1'b1;
			rev_q <= new_rev[1:0];
		end
	end

	// ****************************************************************
	// Status and indicators
	// ****************************************************************
	// Status changes only when accepted; reset command clears it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			status_q <= 8'h00;
		end else if (exec && code_q == `CMD_WR_STATUS && !exec_rej) begin
			status_q <= rx_q[7:0];
		end else if (exec && code_q == `CMD_DEV_RESET) begin
			status_q <= 8'h00;
		end
	end

	// Indicator addresses; classic and adapter modes exclude each other
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_q <= channel_transport_pkg::IND_NONE;
			classic_ind_addr_o <= 64'h0;
			cfg_ind_addr_o <= 64'h0;
			summary_addr_o <= 64'h0;
			ind_area_addr_o <= 64'h0;
			start_bit_o <= 64'h0;
			irq_subclass_o <= 8'h00;
		end else if (exec && !exec_rej) begin
			case (code_q)
				`CMD_CLASSIC_IND: begin
					classic_ind_addr_o <= rx_q[63:0];
					mode_q <= channel_transport_pkg::IND_CLASSIC;
				end
				`CMD_CFG_IND: cfg_ind_addr_o <= rx_q[63:0];
				`CMD_ADAPTER_IND: begin
					summary_addr_o <= rx_q[`AD_SUMMARY_LSB +: 64];
					ind_area_addr_o <= rx_q[`AD_AREA_LSB +: 64];
					start_bit_o <= rx_q[`AD_BIT_LSB +: 64];
					irq_subclass_o <= rx_q[7:0];
					mode_q <= channel_transport_pkg::IND_ADAPTER;
				end
				`CMD_DEV_RESET: mode_q <= channel_transport_pkg::IND_NONE;
				default: mode_q <= mode_q;
			endcase
		end
	end

	// Adapter notify: bit zero is the MSB of the area's first byte
	assign bit_pos = start_bit_o + {48'h0, notify_q_i};
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			notify_o <= 1'b0;
			notify_addr_o <= 64'h0;
			notify_mask_o <= 8'h00;
		end else begin
			notify_o <= notify_i && mode_q == channel_transport_pkg::IND_ADAPTER;
			notify_addr_o <= ind_area_addr_o + {3'h0, bit_pos[63:3]};
			notify_mask_o <= 8'h80 >> bit_pos[2:0];
		end
	end

	// ****************************************************************
	// Queue programming
	// ****************************************************************
	// Reserved word is never looked at; layout follows the revision
	always_ff @(posedge clk_sys_i) begin
		q_wr_o <= 1'b0;
		if (!rst_n_i) begin
			q_index_o <= 16'h0000;
			q_num_o <= 16'h0000;
			q_desc_o <= 64'h0;
			q_align_o <= 32'h0000_0000;
			q_avail_o <= 64'h0;
			q_used_o <= 64'h0;
		end else if (exec && code_q == `CMD_SET_QUEUE) begin
			q_wr_o <= 1'b1;
			if (eff_rev == 2'h0) begin
				q_desc_o <= rx_q[`OLD_ADDR_LSB +: 64];
				q_align_o <= rx_q[`OLD_ALIGN_LSB +: 32];
				q_index_o <= rx_q[`OLD_INDEX_LSB +: 16];
				q_num_o <= rx_q[15:0];
				q_avail_o <= 64'h0;
				q_used_o <= 64'h0;
			end else begin
				q_desc_o <= rx_q[`VQ_DESC_LSB +: 64];
				q_index_o <= rx_q[`VQ_INDEX_LSB +: 16];
				q_num_o <= rx_q[`VQ_NUM_LSB +: 16];
				q_avail_o <= rx_q[`VQ_AVAIL_LSB +: 64];
				q_used_o <= rx_q[63:0];
				q_align_o <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Register port and feature words
	// ****************************************************************
	// Guest config write wins over a host write in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			legacy_ok_q <= `CTRL_RST;
			qmax_q <= `QMAX_RST;
			cfg_q <= 32'h0000_0000;
			status_mask_q <= `STATUS_MASK_RST;
			dev_feat_q[0] <= 32'h0000_0000;
			dev_feat_q[1] <= 32'h0000_0000;
		end else begin
			if (reg_wr_i) begin
				case (reg_addr_i)
					`REG_CTRL: legacy_ok_q <= reg_wdata_i[0];
					`REG_DEV_FEAT0: dev_feat_q[0] <= reg_wdata_i;
					`REG_DEV_FEAT1: dev_feat_q[1] <= reg_wdata_i;
					`REG_QMAX: qmax_q <= reg_wdata_i[15:0];
					`REG_CFG: cfg_q <= reg_wdata_i;
					`REG_STATUS_MASK: status_mask_q <= reg_wdata_i[7:0];
					default: qmax_q <= qmax_q;
				endcase
			end
			if (exec && code_q == `CMD_WR_CFG) begin
				cfg_q <= rx_q[31:0];
			end
		end
	end

	// Driver feature words, little-endian in the block
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			drv_feat_q[0] <= 32'h0000_0000;
			drv_feat_q[1] <= 32'h0000_0000;
		end else if (exec && code_q == `CMD_WR_FEAT && rx_q[7:1] == 7'h00) begin
			drv_feat_q[rx_q[0]] <= {rx_q[15:8], rx_q[23:16], rx_q[31:24], rx_q[39:32]};
		end
	end

	// Read data stands only in the cycle after each strobe cycle; unmapped reads give zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !reg_rd_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			case (reg_addr_i)
				`REG_CTRL: reg_rdata_o <= {31'h0, legacy_ok_q};
				`REG_DEV_FEAT0: reg_rdata_o <= dev_feat_q[0];
				`REG_DEV_FEAT1: reg_rdata_o <= dev_feat_q[1];
				`REG_QMAX: reg_rdata_o <= {16'h0000, qmax_q};
				`REG_CFG: reg_rdata_o <= cfg_q;
				`REG_STATUS_MASK: reg_rdata_o <= {24'h000000, status_mask_q};
				`REG_STATE: reg_rdata_o <= {16'h0000, 2'h0, mode_q, rev_set_q, implied_q,
					rev_q, status_q};
				`REG_DRV_FEAT0: reg_rdata_o <= drv_feat_q[0];
				`REG_DRV_FEAT1: reg_rdata_o <= drv_feat_q[1];
				default: reg_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_rev_too_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec && code_q == `CMD_SET_REV && new_rev > 16'h0002 |=> done_o && reject_o)
		else $error("revision above two not rejected");
	a_rev_zero_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec && code_q == `CMD_SET_REV && new_rev == 16'h0000 && !legacy_ok_q && subch_enable_i
		|=> reject_o && rev_set_q == $past(rev_set_q))
		else $error("revision zero accepted without legacy support");
	a_status_read_rev: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_q == channel_transport_pkg::ST_IDLE && cmd_valid_i
		&& cmd_code_i == `CMD_RD_STATUS && rev_q < 2'h2 |=> done_o && reject_o)
		else $error("status read allowed below revision two");
	a_rev_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		rev_set_q && subch_enable_i |=> rev_q == $past(rev_q) && rev_set_q)
		else $error("selected revision changed");
	a_rev_unset_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!subch_enable_i |=> !rev_set_q)
		else $error("revision survives disabled subchannel");
	a_early_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_q == channel_transport_pkg::ST_IDLE && cmd_valid_i && !rev_set_q
		&& cmd_code_i != `CMD_SET_REV && !legacy_ok_q |=> reject_o && done_o)
		else $error("command before revision not rejected");
	a_status_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec && code_q == `CMD_WR_STATUS && exec_rej |=> $stable(status_q) && reject_o)
		else $error("refused status write changed status");
	a_classic_excluded: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec && code_q == `CMD_CLASSIC_IND && mode_q == channel_transport_pkg::IND_ADAPTER
		|=> reject_o ##0 mode_q == channel_transport_pkg::IND_ADAPTER)
		else $error("classic setup accepted after adapter setup");
	a_queue_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec && code_q == `CMD_SET_QUEUE && rev_q != 2'h0 && rev_set_q
		|=> q_wr_o && q_num_o == rx_q[`VQ_NUM_LSB +: 16] && q_used_o == rx_q[63:0])
		else $error("set-queue fields misplaced");
endmodule

// [dv/guest_driver_model.sv]
// Guest driver model: issues channel commands and gathers the answers
`timescale 1ns/10ps
module guest_driver_model (
	input wire logic clk_i, // System clock
	input wire logic din_ready_i, // Device wants bytes
	input wire logic dout_valid_i, // Device byte valid
	input wire logic [7:0] dout_i, // Device byte
	input wire logic done_i, // Command ended
	input wire logic reject_i, // Command refused
	output logic cmd_valid_o, // Command start
	output logic [7:0] cmd_code_o, // Command code
	output logic [15:0] cmd_len_o, // Buffer length
	output logic din_valid_o, // Byte valid
	output logic [7:0] din_o // Byte to device
);
	// ****************
	// Command driver
	// ****************
	logic rej; // Outcome of the last command
	logic [31:0] got; // Answer bytes, first byte highest
	// Idle levels at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_len_o = 16'h0000;
		din_valid_o = 1'b0;
		din_o = 8'h00;
	end
	// One command; a byte is held until the device takes it
	task automatic run(input logic [7:0] code, input logic [15:0] len, input int nin,
		input logic [255:0] blk);
		int left;
		left = nin;
		got = 32'h00000000;
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= code;
		cmd_len_o <= len;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		for (int i = 0; i < 200; i++) begin
			if (left > 0) begin
				din_valid_o <= 1'b1;
				din_o <= blk[8*left-1 -: 8]; // First byte first
			end else begin
				din_valid_o <= 1'b0;
				din_o <= ~din_o; // Idle line inverts each cycle, so stale data never holds for two cycles
			end
			@(posedge clk_i);
			if (din_valid_o && din_ready_i)
				left--;
			if (dout_valid_i)
				got = {got[23:0], dout_i}; // Big-endian gather
			if (done_i)
				break;
		end
		// A missing end leaves an unknown outcome, so it cannot pass
		rej = done_i ? reject_i : 1'bx;
		din_valid_o <= 1'b0;
	endtask
endmodule

// [dv/channel_transport_command_handler_tb.sv]
// Testbench of the channel transport command handler
`timescale 1ns/10ps
`include "channel_transport_cfg.svh"
module channel_transport_command_handler_tb;
	// ****************
	// Bench and tests
	// ****************
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic subch_enable_i = 1'b1;
	logic cmd_valid_i, din_valid_i, din_ready_o, dout_valid_o, done_o, reject_o;
	logic [7:0] cmd_code_i, din_i, dout_o, irq_subclass_o, status_o, notify_mask_o;
	logic [15:0] cmd_len_i, q_index_o, q_num_o;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic notify_i = 1'b0;
	logic [15:0] notify_q_i = 16'h0000;
	logic [31:0] reg_rdata_o, q_align_o;
	logic q_wr_o, notify_o;
	logic [1:0] ind_mode_o;
	logic [63:0] q_desc_o, q_avail_o, q_used_o, classic_ind_addr_o, cfg_ind_addr_o;
	logic [63:0] summary_addr_o, ind_area_addr_o, start_bit_o, notify_addr_o;
	int n_fail = 0;
	int comparisons = 0;
	// 40 MHz clock
	always #12.5 clk_sys_i = ~clk_sys_i;
	channel_transport_command_handler u_channel_transport_command_handler (
		.clk_sys_i, .rst_n_i, .subch_enable_i, .cmd_valid_i, .cmd_code_i, .cmd_len_i,
		.din_valid_i, .din_i, .din_ready_o, .dout_valid_o, .dout_o, .done_o, .reject_o,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .q_wr_o,
		.q_index_o, .q_num_o, .q_desc_o, .q_align_o, .q_avail_o, .q_used_o,
		.classic_ind_addr_o, .cfg_ind_addr_o, .summary_addr_o, .ind_area_addr_o,
		.start_bit_o, .irq_subclass_o, .ind_mode_o, .status_o, .notify_i, .notify_q_i,
		.notify_o, .notify_addr_o, .notify_mask_o);
	guest_driver_model u_guest_driver_model (.clk_i(clk_sys_i), .din_ready_i(din_ready_o),
		.dout_valid_i(dout_valid_o), .dout_i(dout_o), .done_i(done_o), .reject_i(reject_o),
		.cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_len_o(cmd_len_i),
		.din_valid_o(din_valid_i), .din_o(din_i));
	// Value compare
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %0h expected %0h", $time, g, e);
		end
	endtask
	// Refusal compare on the last command
	task automatic chk_rej(input logic e);
		chk({63'h0, u_guest_driver_model.rej}, {63'h0, e});
	endtask
	// Command through the guest model, then its outcome
	task automatic c(input logic [7:0] code, input logic [15:0] len, input int nin,
		input logic [255:0] blk, input logic e);
		u_guest_driver_model.run(code, len, nin, blk);
		chk_rej(e);
	endtask
	// Register write, one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	// Register read; data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_sys_i);
		chk(reg_rdata_o, e);
	endtask
	// Verdict and end of run
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rchk(`REG_QMAX, 32'h00000100);
		rchk(`REG_STATUS_MASK, 32'h000000FF);
		rchk(`REG_CTRL, 32'h00000000);
		rchk(8'h40, 32'h00000000);
		c(`CMD_WR_STATUS, `LEN_STATUS, 1, 256'h01, 1'b1);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00030000, 1'b1);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00020001, 1'b1);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00000000, 1'b1);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00020000, 1'b0);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00010000, 1'b1);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00020000, 1'b0);
		c(`CMD_WR_STATUS, `LEN_STATUS, 1, 256'h0F, 1'b0);
		wr(`REG_STATUS_MASK, 32'h0000000F);
		c(`CMD_WR_STATUS, `LEN_STATUS, 1, 256'h1F, 1'b1);
		c(`CMD_RD_STATUS, `LEN_STATUS, 0, 256'h0, 1'b0);
		chk(u_guest_driver_model.got, 64'h0F);
		wr(`REG_QMAX, 32'h00001234);
		c(`CMD_RD_QCFG, `LEN_QCFG_IN, 2, 256'h0005, 1'b0);
		chk(u_guest_driver_model.got, 64'h1234);
		c(`CMD_SET_QUEUE, `LEN_VQ, 32, {64'h0102030405060708, 32'hFFFFFFFF, 16'h0007,
			16'h0080, 64'hA0A1A2A3A4A5A6A7, 64'hB0B1B2B3B4B5B6B7}, 1'b0);
		chk({63'h0, q_wr_o}, 64'h1);
		chk(q_desc_o, 64'h0102030405060708);
		chk({q_index_o, q_num_o, q_align_o}, {16'h0007, 16'h0080, 32'h0});
		chk(q_avail_o ^ q_used_o, 64'h1010101010101010);
		chk(q_used_o, 64'hB0B1B2B3B4B5B6B7);
		wr(`REG_DEV_FEAT0, 32'h11223344);
		c(`CMD_RD_FEAT, `LEN_FEAT, 5, 256'h00, 1'b0);
		chk(u_guest_driver_model.got, 64'h44332211);
		c(`CMD_RD_FEAT, `LEN_FEAT, 5, 256'h02, 1'b0);
		chk(u_guest_driver_model.got, 64'h0);
		c(`CMD_WR_FEAT, `LEN_FEAT, 5, 256'hDDCCBBAA01, 1'b0);
		rchk(`REG_DRV_FEAT1, 32'hAABBCCDD);
		wr(`REG_CFG, 32'hA1B2C3D4);
		c(`CMD_RD_CFG, `LEN_CFG, 0, 256'h0, 1'b0);
		chk(u_guest_driver_model.got, 64'hA1B2C3D4);
		c(`CMD_WR_CFG, `LEN_CFG, 4, 256'h01020304, 1'b0);
		rchk(`REG_CFG, 32'h01020304);
		c(`CMD_CFG_IND, `LEN_IND, 8, 256'h12345678, 1'b0);
		chk(cfg_ind_addr_o, 64'h12345678);
		c(`CMD_ADAPTER_IND, `LEN_ADAPTER, 25, {64'h5000, 64'h6000, 64'hD, 8'h05}, 1'b0);
		chk(summary_addr_o ^ ind_area_addr_o, 64'h3000);
		chk({start_bit_o[53:0], ind_mode_o, irq_subclass_o}, {54'hD, 2'h2, 8'h05});
		c(`CMD_CLASSIC_IND, `LEN_IND, 8, 256'h7000, 1'b1);
		@(posedge clk_sys_i);
		notify_i <= 1'b1;
		notify_q_i <= 16'h0002;
		@(posedge clk_sys_i);
		notify_i <= 1'b0;
		@(posedge clk_sys_i);
		chk({notify_o, notify_mask_o, notify_addr_o[54:0]}, {1'b1, 8'h01, 55'h6001});
		c(`CMD_DEV_RESET, 16'h0000, 0, 256'h0, 1'b0);
		chk({ind_mode_o, status_o}, 64'h0);
		c(`CMD_CLASSIC_IND, `LEN_IND, 8, 256'h7000, 1'b0);
		chk(classic_ind_addr_o, 64'h7000);
		// Disabling the subchannel drops the revision
		@(posedge clk_sys_i);
		subch_enable_i <= 1'b0;
		@(posedge clk_sys_i);
		subch_enable_i <= 1'b1;
		c(`CMD_WR_STATUS, `LEN_STATUS, 1, 256'h01, 1'b1);
		wr(`REG_CTRL, 32'h00000001);
		c(`CMD_SET_QUEUE, `LEN_VQ_OLD, 16, {64'hC000, 32'h1000, 16'h3, 16'h40}, 1'b0);
		chk({q_index_o, q_num_o, q_align_o}, {16'h0003, 16'h0040, 32'h1000});
		chk(q_desc_o ^ q_used_o, 64'hC000);
		c(`CMD_SET_REV, `LEN_REV, 4, 256'h00000000, 1'b1);
		c(`CMD_RD_STATUS, `LEN_STATUS, 0, 256'h0, 1'b1);
		test_done();
	end
endmodule
